// ---- hdl/tsu_divider.sv ----
`timescale 1ns/1ps
module tsu_divider #(
	parameter int NUM_W = 34,
	parameter int DEN_W = 17
) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic start_in,
	input wire logic signed [NUM_W-1:0] num_in,
	input wire logic signed [DEN_W-1:0] den_in,
	output logic done_out,
	output logic signed [NUM_W-1:0] quot_out
);
	import tsu_pkg::*;

	localparam int CNT_W = $clog2(NUM_W + 1);

	generate
		if (NUM_W <= DEN_W || DEN_W < 2) begin : g_bad_width
			$error("tsu_divider: NUM_W must exceed DEN_W");
		end
	endgenerate

	logic [NUM_W-1:0] q_reg;
	logic [DEN_W-1:0] rem_reg;
	logic [DEN_W-1:0] dmag_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic neg_reg;
	logic run_reg;
	logic done_reg;
	logic signed [NUM_W-1:0] quot_reg;
	logic [DEN_W:0] trial;
	logic [DEN_W:0] diff;
	logic [NUM_W-1:0] q_step;
	logic [NUM_W-1:0] num_mag;
	logic [DEN_W-1:0] den_mag;

	assign num_mag = num_in[NUM_W-1] ? NUM_W'(-num_in) : NUM_W'(num_in);
	assign den_mag = den_in[DEN_W-1] ? DEN_W'(-den_in) : DEN_W'(den_in);
	assign trial = {rem_reg, q_reg[NUM_W-1]};
	assign diff = trial - {1'b0, dmag_reg};
	assign q_step = {q_reg[NUM_W-2:0], ~diff[DEN_W]};

	// Magnitudes are divided, then the sign applied, so the quotient truncates toward zero
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			q_reg <= '0;
			rem_reg <= '0;
			dmag_reg <= '0;
			cnt_reg <= '0;
			neg_reg <= 1'b0;
			run_reg <= 1'b0;
		end else if (start_in) begin
			q_reg <= num_mag;
			rem_reg <= '0;
			dmag_reg <= den_mag;
			cnt_reg <= CNT_W'(NUM_W);
			neg_reg <= num_in[NUM_W-1] ^ den_in[DEN_W-1];
			run_reg <= 1'b1;
		end else if (run_reg) begin
			q_reg <= q_step;
			rem_reg <= diff[DEN_W] ? trial[DEN_W-1:0] : diff[DEN_W-1:0];
			cnt_reg <= cnt_reg - CNT_W'(1);
			run_reg <= (cnt_reg != CNT_W'(1));
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			done_reg <= 1'b0;
			quot_reg <= '0;
		end else begin
			done_reg <= run_reg && (cnt_reg == CNT_W'(1));
			if (run_reg && (cnt_reg == CNT_W'(1))) begin
				quot_reg <= neg_reg ? -$signed(q_step) : $signed(q_step);
			end
		end
	end

	assign done_out = done_reg;
	assign quot_out = quot_reg;

endmodule : tsu_divider

// ---- hdl/tsu_table_statistics_unit.sv ----
// Behaviour
// - Input false: no operation, flag false; else execute, unless the length is out of range: error, flag false.
// - Table words compare as signed 16-bit.
// - Maximum of n words; value, then position.
// - Minimum of n words; value, then position.
// - Tied maxima report the lowest position.
// - Tied minima report the lowest position.
// - Index register destination drops the position word.
// - Positions count from zero at table base.
// - Mean of n words into one result word.
// - Function value from 2n parameter words, n<=32.
// - Abscissas then ordinates; interpolate between breakpoints.
// - Input below first abscissa returns first ordinate.
// - Input above last abscissa returns last ordinate.
`timescale 1ns/1ps
`include "tsu_cfg.svh"
module tsu_table_statistics_unit #(
	parameter int ADDR_W = `TSU_ADDR_W
) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic start_in,
	input wire logic instr_in,
	input wire tsu_pkg::tsu_op_type op_in,
	input wire logic [`TSU_LEN_W-1:0] len_in,
	input wire logic [ADDR_W-1:0] table_base_in,
	input wire logic [`TSU_DATA_W-1:0] fg_x_in,
	input wire logic [ADDR_W-1:0] dest_in,
	input wire logic dest_is_index_in,
	input wire logic [`TSU_DATA_W-1:0] mem_rdata_in,
	output logic [ADDR_W-1:0] mem_addr_out,
	output logic mem_rd_out,
	output logic mem_wr_out,
	output logic [`TSU_DATA_W-1:0] mem_wdata_out,
	output logic busy_out,
	output logic done_out,
	output logic flag_out,
	output logic error_out
);
	import tsu_pkg::*;

	localparam int SUM_W = `TSU_DATA_W + `TSU_LEN_W - 1;
	localparam int DEN_W = `TSU_DATA_W + 1;
	localparam int NUM_W = 2 * DEN_W;

	generate
		if (ADDR_W < `TSU_LEN_W) begin : g_bad_addr
			$error("tsu_table_statistics_unit: ADDR_W too narrow");
		end
	endgenerate

	function automatic logic len_in_range(input tsu_op_type op, input logic [`TSU_LEN_W-1:0] len);
		logic [`TSU_LEN_W-1:0] top;
		top = (op == piecewise_function_opcode) ? `TSU_FG_LEN_MAX : `TSU_TBL_LEN_MAX;
		return (len >= `TSU_LEN_MIN) && (len <= top);
	endfunction : len_in_range

	tsu_state_type state_reg;
	tsu_op_type op_reg;
	logic [`TSU_LEN_W-1:0] len_reg;
	logic [`TSU_LEN_W-1:0] k_reg;
	logic [`TSU_LEN_W-1:0] pos_reg;
	logic [ADDR_W-1:0] base_reg;
	logic [ADDR_W-1:0] dest_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [`TSU_DATA_W-1:0] wdata_reg;
	logic signed [`TSU_DATA_W-1:0] x_reg;
	logic signed [`TSU_DATA_W-1:0] best_reg;
	logic signed [`TSU_DATA_W-1:0] xprev_reg;
	logic signed [`TSU_DATA_W-1:0] xcur_reg;
	logic signed [`TSU_DATA_W-1:0] yprev_reg;
	logic signed [`TSU_DATA_W-1:0] val_reg;
	logic signed [SUM_W-1:0] sum_reg;
	logic signed [NUM_W-1:0] num_reg;
	logic signed [DEN_W-1:0] den_reg;
	logic dest_idx_reg;
	logic yph_reg;
	logic seg_reg;
	logic yfirst_reg;
	logic ok_reg;
	logic rej_reg;
	logic rd_reg;
	logic wr_reg;
	logic flag_reg;
	logic done_reg;
	logic err_reg;

	logic signed [`TSU_DATA_W-1:0] rd_s;
	logic signed [SUM_W-1:0] sum_add;
	logic signed [DEN_W-1:0] dx_num;
	logic signed [DEN_W-1:0] dx_den;
	logic signed [DEN_W-1:0] dy;
	logic last;
	logic take;
	logic table_mean_op;
	logic piecewise_function_op;
	logic maxmin;
	logic pos_en;
	logic div_start;
	logic div_done;
	logic signed [NUM_W-1:0] div_quot;
	logic [ADDR_W-1:0] tbl_addr;
	logic [ADDR_W-1:0] y_addr;

	assign rd_s = $signed(mem_rdata_in);
	assign sum_add = sum_reg + SUM_W'(rd_s);
	assign dx_num = $signed({x_reg[`TSU_DATA_W-1], x_reg}) -
		$signed({xprev_reg[`TSU_DATA_W-1], xprev_reg});
	assign dx_den = $signed({xcur_reg[`TSU_DATA_W-1], xcur_reg}) -
		$signed({xprev_reg[`TSU_DATA_W-1], xprev_reg});
	assign dy = $signed({rd_s[`TSU_DATA_W-1], rd_s}) -
		$signed({yprev_reg[`TSU_DATA_W-1], yprev_reg});
	assign last = (k_reg == len_reg - `TSU_STEP);
	assign table_mean_op = (op_reg == table_mean_opcode);
	assign piecewise_function_op = (op_reg == piecewise_function_opcode);
	assign maxmin = !table_mean_op && !piecewise_function_op;
	// Strict compare keeps the earlier position on a tie
	assign take = (k_reg == `TSU_POS_ORIGIN) ||
		((op_reg == table_max_opcode) ? (rd_s > best_reg) : (rd_s < best_reg));
	assign pos_en = maxmin && !dest_idx_reg;
	assign tbl_addr = base_reg + ADDR_W'(k_reg);
	assign y_addr = base_reg + ADDR_W'(len_reg) + ADDR_W'(k_reg);
	assign div_start = (state_reg == st_dstart);

	tsu_divider #(
		.NUM_W(NUM_W),
		.DEN_W(DEN_W)
	) u_div (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.start_in(div_start),
		.num_in(num_reg),
		.den_in(den_reg),
		.done_out(div_done),
		.quot_out(div_quot)
	);

	// Sequencer and datapath; one word costs three cycles to keep address and data registered
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			state_reg <= st_idle;
			op_reg <= table_max_opcode;
			len_reg <= '0;
			k_reg <= '0;
			pos_reg <= '0;
			base_reg <= '0;
			dest_reg <= '0;
			x_reg <= '0;
			best_reg <= '0;
			xprev_reg <= '0;
			xcur_reg <= '0;
			yprev_reg <= '0;
			val_reg <= '0;
			sum_reg <= '0;
			num_reg <= '0;
			den_reg <= '0;
			dest_idx_reg <= 1'b0;
			yph_reg <= 1'b0;
			seg_reg <= 1'b0;
			yfirst_reg <= 1'b0;
			ok_reg <= 1'b0;
			rej_reg <= 1'b0;
		end else begin
			case (state_reg)
				st_idle: begin
					if (start_in) begin
						op_reg <= op_in;
						len_reg <= len_in;
						base_reg <= table_base_in;
						x_reg <= $signed(fg_x_in);
						dest_reg <= dest_in;
						dest_idx_reg <= dest_is_index_in;
						k_reg <= `TSU_POS_ORIGIN;
						sum_reg <= '0;
						yph_reg <= 1'b0;
						seg_reg <= 1'b0;
						ok_reg <= instr_in && len_in_range(op_in, len_in);
						rej_reg <= instr_in && !len_in_range(op_in, len_in);
						if (instr_in && len_in_range(op_in, len_in)) begin
							state_reg <= st_fetch;
						end else begin
							state_reg <= st_done;
						end
					end
				end
				st_fetch: state_reg <= st_rdcyc;
				st_rdcyc: state_reg <= st_check;
				st_check: begin
					if (yph_reg) begin
						if (seg_reg && yfirst_reg) begin
							yprev_reg <= rd_s;
							yfirst_reg <= 1'b0;
							k_reg <= k_reg + `TSU_STEP;
							state_reg <= st_fetch;
						end else if (seg_reg) begin
							num_reg <= dx_num * dy;
							den_reg <= dx_den;
							state_reg <= st_dstart;
						end else begin
							val_reg <= rd_s;
							state_reg <= st_wval;
						end
					end else begin
						case (op_reg)
							table_max_opcode, table_min_opcode: begin
								if (take) begin
									best_reg <= rd_s;
									pos_reg <= k_reg;
								end
								if (last) begin
									val_reg <= take ? rd_s : best_reg;
									state_reg <= st_wval;
								end else begin
									k_reg <= k_reg + `TSU_STEP;
									state_reg <= st_fetch;
								end
							end
							table_mean_opcode: begin
								sum_reg <= sum_add;
								if (last) begin
									num_reg <= NUM_W'(sum_add);
									den_reg <= DEN_W'(len_reg);
									state_reg <= st_dstart;
								end else begin
									k_reg <= k_reg + `TSU_STEP;
									state_reg <= st_fetch;
								end
							end
							default: begin
								// Abscissas are assumed ascending; equal neighbours never divide by zero
								state_reg <= st_fetch;
								if (x_reg < rd_s) begin
									yph_reg <= 1'b1;
									if (k_reg == `TSU_POS_ORIGIN) begin
										seg_reg <= 1'b0;
									end else begin
										seg_reg <= 1'b1;
										yfirst_reg <= 1'b1;
										xcur_reg <= rd_s;
										k_reg <= k_reg - `TSU_STEP;
									end
								end else if (x_reg == rd_s || last) begin
									yph_reg <= 1'b1;
									seg_reg <= 1'b0;
								end else begin
									xprev_reg <= rd_s;
									k_reg <= k_reg + `TSU_STEP;
								end
							end
						endcase
					end
				end
				st_dstart: state_reg <= st_dwait;
				st_dwait: begin
					if (div_done) begin
						if (piecewise_function_op) begin
							val_reg <= yprev_reg + div_quot[`TSU_DATA_W-1:0];
						end else begin
							val_reg <= div_quot[`TSU_DATA_W-1:0];
						end
						state_reg <= st_wval;
					end
				end
				st_wval: state_reg <= st_wpos;
				st_wpos: state_reg <= st_done;
				st_done: state_reg <= st_idle;
				default: state_reg <= st_idle;
			endcase
		end
	end

	// Memory port; strobes and address come one cycle after the state that asks for them
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
			addr_reg <= '0;
			wdata_reg <= '0;
		end else begin
			rd_reg <= (state_reg == st_fetch);
			wr_reg <= (state_reg == st_wval) || ((state_reg == st_wpos) && pos_en);
			case (state_reg)
				st_fetch: addr_reg <= yph_reg ? y_addr : tbl_addr;
				st_wval: begin
					addr_reg <= dest_reg;
					wdata_reg <= val_reg;
				end
				st_wpos: begin
					addr_reg <= dest_reg + ADDR_W'(`TSU_POS_OFS);
					wdata_reg <= `TSU_DATA_W'(pos_reg);
				end
				default: begin
				end
			endcase
		end
	end

	// Status; the flag drops on the next clock edge after the instruction input goes false
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			flag_reg <= `TSU_FLAG_RST;
			done_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			done_reg <= (state_reg == st_done);
			err_reg <= (state_reg == st_done) && rej_reg;
			if (!instr_in) begin
				flag_reg <= 1'b0;
			end else if (state_reg == st_done) begin
				flag_reg <= ok_reg;
			end
		end
	end

	assign mem_addr_out = addr_reg;
	assign mem_rd_out = rd_reg;
	assign mem_wr_out = wr_reg;
	assign mem_wdata_out = wdata_reg;
	assign busy_out = (state_reg != st_idle);
	assign done_out = done_reg;
	assign flag_out = flag_reg;
	assign error_out = err_reg;

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);

	sequence s_word_seen;
		(state_reg == st_check) && !yph_reg;
	endsequence

	sequence s_value_write;
		mem_wr_out && (mem_addr_out == dest_reg);
	endsequence

	a_off_no_exec: assert property (
		start_in && !busy_out && !instr_in |=> !mem_rd_out ##1 done_out && !flag_out)
		else $error("Idle instruction did not finish with flag false");

	a_on_flag_level: assert property (
		$rose(done_out) && $past(instr_in) |-> flag_out == ok_reg)
		else $error("Completion flag does not match execution");

	a_len_reject: assert property (
		start_in && !busy_out && instr_in && !len_in_range(op_in, len_in)
		|=> ##1 error_out && done_out && !flag_out && !mem_wr_out)
		else $error("Out-of-range length not rejected");

	a_max_tracks: assert property (
		s_word_seen and (op_reg == table_max_opcode) |=> best_reg >= $signed($past(mem_rdata_in)))
		else $error("Maximum lost a larger word");

	a_min_tracks: assert property (
		s_word_seen and (op_reg == table_min_opcode) |=> best_reg <= $signed($past(mem_rdata_in)))
		else $error("Minimum lost a smaller word");

	a_tie_keeps_pos: assert property (
		s_word_seen and maxmin && (k_reg != `TSU_POS_ORIGIN) && (rd_s == best_reg)
		|=> $stable(pos_reg))
		else $error("Tie moved the reported position");

	a_pos_origin: assert property (
		s_word_seen and maxmin && (k_reg == `TSU_POS_ORIGIN)
		|=> pos_reg == `TSU_POS_ORIGIN && best_reg == $signed($past(mem_rdata_in)))
		else $error("First word not taken at position zero");

	a_pos_write: assert property (
		s_value_write and pos_en |=> mem_wr_out
		&& mem_addr_out == dest_reg + ADDR_W'(`TSU_POS_OFS)
		&& mem_wdata_out == `TSU_DATA_W'(pos_reg))
		else $error("Position word not written after value");

	a_index_drop: assert property (
		mem_wr_out && dest_idx_reg |-> mem_addr_out == dest_reg)
		else $error("Position written to index destination");

	a_fg_below: assert property (
		s_word_seen and piecewise_function_op && (k_reg == `TSU_POS_ORIGIN) && (x_reg < rd_s)
		|=> yph_reg && !seg_reg && k_reg == `TSU_POS_ORIGIN)
		else $error("Input below first abscissa not clamped");

	a_fg_above: assert property (
		s_word_seen and piecewise_function_op && last && (x_reg > rd_s)
		|=> yph_reg && !seg_reg && k_reg == $past(k_reg))
		else $error("Input above last abscissa not clamped");

endmodule : tsu_table_statistics_unit

// ---- include/tsu_cfg.svh ----
`ifndef TSU_CFG_SVH
`define TSU_CFG_SVH

`define TSU_DATA_W 16
`define TSU_ADDR_W 16
`define TSU_LEN_W 7
`define TSU_LEN_MIN 7'h01
`define TSU_TBL_LEN_MAX 7'h40
`define TSU_FG_LEN_MAX 7'h20
`define TSU_POS_ORIGIN 7'h00
`define TSU_STEP 7'h01
`define TSU_POS_OFS 16'h0001
`define TSU_FLAG_RST 1'b0

`endif

// ---- include/tsu_pkg.sv ----
package tsu_pkg;

	typedef enum logic [1:0] {
		table_max_opcode = 2'h0,
		table_min_opcode = 2'h1,
		table_mean_opcode = 2'h2,
		piecewise_function_opcode = 2'h3
	} tsu_op_type;

	typedef enum logic [3:0] {
		st_idle = 4'h0,
		st_fetch = 4'h1,
		st_rdcyc = 4'h2,
		st_check = 4'h3,
		st_dstart = 4'h4,
		st_dwait = 4'h5,
		st_wval = 4'h6,
		st_wpos = 4'h7,
		st_done = 4'h8
	} tsu_state_type;

endpackage : tsu_pkg

// ---- test/tsu_table_statistics_unit_tb.sv ----
`timescale 1ns/1ps
module tsu_table_statistics_unit_tb;
import tsu_pkg::*;
localparam logic [15:0] DEST = 16'h2000;
localparam logic [15:0] FGB = 16'h0300;
logic sys_clk_in = 1'b0;
logic sys_rst_in = 1'b1;
logic start_in = 1'b0;
logic instr_in = 1'b0;
tsu_op_type op_in = table_max_opcode;
logic [6:0] len_in = 7'h01;
logic [15:0] table_base_in = 16'h0000;
logic [15:0] fg_x_in = 16'h0000;
logic [15:0] dest_in = 16'h0000;
logic dest_is_index_in = 1'b0;
logic [15:0] mem_rdata_in = 16'h0000;
logic [15:0] mem_addr_out;
logic [15:0] mem_wdata_out;
logic mem_rd_out;
logic mem_wr_out;
logic busy_out;
logic done_out;
logic flag_out;
logic error_out;
logic [15:0] mem [0:65535];
logic rd_q = 1'b0;
logic [15:0] ra_q = 16'h0000;
int wr_cnt = 0;
int wr0 = 0;
int error_cnt = 0;
int checks = 0;
int seed = 32'hef709a4f;
int got_cyc;
logic got_err;
logic got_flag;
int ex [10] = '{100, 10000, -1000, 10, 0, 200, -300, 20000, -30, 20};
int fx [8] = '{-2000, -100, 100, 2000, -1800, -300, 300, 1800};
int xs [8] = '{-2500, -2000, -1000, 0, 1500, 2000, 3000, 32767};

tsu_table_statistics_unit u_tsu_table_statistics_unit (
	.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .start_in(start_in),
	.instr_in(instr_in), .op_in(op_in), .len_in(len_in), .table_base_in(table_base_in),
	.fg_x_in(fg_x_in), .dest_in(dest_in), .dest_is_index_in(dest_is_index_in),
	.mem_rdata_in(mem_rdata_in), .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
	.mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out), .busy_out(busy_out),
	.done_out(done_out), .flag_out(flag_out), .error_out(error_out)
);

always #2 sys_clk_in = ~sys_clk_in;

// Memory with one cycle of read latency; the bus toggles when no read is due
always @(posedge sys_clk_in) begin
	rd_q <= mem_rd_out;
	ra_q <= mem_addr_out;
	if (mem_wr_out === 1'b1) begin
		mem[mem_addr_out] <= mem_wdata_out;
		wr_cnt <= wr_cnt + 1;
	end
end

always @(negedge sys_clk_in) mem_rdata_in <= rd_q ? mem[ra_q] : ~mem_rdata_in;

task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
	checks++;
	if (got !== exp) begin
		error_cnt++;
		$display("unexpected word at %0t: got %h expected %h", $time, got, exp);
	end
endtask : chk16

task automatic chk1(input logic got, input logic exp);
	checks++;
	if (got !== exp) begin
		error_cnt++;
		$display("unexpected bit at %0t: got %h expected %h", $time, got, exp);
	end
endtask : chk1

task automatic test_done();
	$display("checks %0d error_cnt %0d", checks, error_cnt);
	if (error_cnt == 0 && checks > 0) begin
		$display("Regression OK");
	end else begin
		$display("Regression broken");
	end
	$finish;
endtask : test_done

// Destination words are poisoned so a missing or stray write shows up
task automatic run(input tsu_op_type op, input int n, input logic [15:0] b,
		input logic [15:0] x, input logic idx, input logic ins);
	@(negedge sys_clk_in);
	op_in = op;
	len_in = 7'(n);
	table_base_in = b;
	fg_x_in = x;
	dest_in = DEST;
	dest_is_index_in = idx;
	instr_in = ins;
	mem[DEST] = 16'hA5A5;
	mem[DEST + 16'h0001] = 16'h5A5A;
	wr0 = wr_cnt;
	start_in = 1'b1;
	@(negedge sys_clk_in);
	start_in = 1'b0;
	got_cyc = 1;
	while (done_out !== 1'b1) begin
		if (got_cyc > 400) begin
			error_cnt++;
			$display("unexpected hang at %0t: got %h expected %h", $time, done_out, 1'b1);
			test_done();
		end
		@(negedge sys_clk_in);
		got_cyc++;
	end
	got_err = error_out;
	got_flag = flag_out;
endtask : run

function automatic void exp_stat(input tsu_op_type op, input int n, input logic [15:0] b,
		output logic [15:0] v, output logic [15:0] p);
	int best;
	int bp;
	int sum;
	int w;
	best = $signed(mem[b]);
	bp = 0;
	sum = 0;
	for (int i = 0; i < n; i++) begin
		w = $signed(mem[b + i]);
		sum += w;
		if ((op == table_max_opcode && w > best) || (op == table_min_opcode && w < best)) begin
			best = w;
			bp = i;
		end
	end
	v = (op == table_mean_opcode) ? 16'(sum / n) : best[15:0];
	p = bp[15:0];
endfunction : exp_stat

function automatic logic [15:0] exp_fg(input int n, input logic [15:0] xv);
	longint x;
	longint xk;
	longint yk;
	longint xp;
	longint yp;
	x = $signed(xv);
	for (int k = 0; k < n; k++) begin
		xk = $signed(mem[FGB + k]);
		yk = $signed(mem[FGB + n + k]);
		if (xk == x || (xk > x && k == 0)) begin
			return yk[15:0];
		end
		if (xk > x) begin
			xp = $signed(mem[FGB + k - 1]);
			yp = $signed(mem[FGB + n + k - 1]);
			return 16'(yp + (x - xp) * (yk - yp) / (xk - xp));
		end
	end
	return mem[FGB + 2 * n - 1];
endfunction : exp_fg

task automatic stat(input tsu_op_type op, input int n, input logic [15:0] b, input logic idx);
	logic [15:0] v;
	logic [15:0] p;
	logic nopos;
	exp_stat(op, n, b, v, p);
	nopos = (op == table_mean_opcode) || idx;
	run(op, n, b, 16'h0000, idx, 1'b1);
	chk16(mem[DEST], v);
	chk16(mem[DEST + 16'h0001], nopos ? 16'h5A5A : p);
	chk16(16'(wr_cnt - wr0), nopos ? 16'h0001 : 16'h0002);
	chk1(got_flag, 1'b1);
	chk1(got_err, 1'b0);
	chk16(16'(got_cyc), 16'((op == table_mean_opcode) ? 3 * n + 40 : 3 * n + 4));
endtask : stat

task automatic quiet(input tsu_op_type op, input int n, input logic ins, input logic e);
	run(op, n, 16'h0100, 16'h0000, 1'b0, ins);
	chk1(got_err, e);
	chk1(got_flag, 1'b0);
	chk16(16'(wr_cnt - wr0), 16'h0000);
	chk16(16'(got_cyc), 16'h0002);
endtask : quiet

task automatic fg(input int n, input logic [15:0] x);
	logic [15:0] e;
	e = exp_fg(n, x);
	run(piecewise_function_opcode, n, FGB, x, 1'b0, 1'b1);
	chk16(mem[DEST], e);
	chk16(16'(wr_cnt - wr0), 16'h0001);
	chk1(got_flag, 1'b1);
endtask : fg

initial begin
	int n;
	int a;
	repeat (5) @(negedge sys_clk_in);
	sys_rst_in = 1'b0;
	chk1(busy_out, 1'b0);
	chk1(flag_out, 1'b0);
	for (int i = 0; i < 10; i++) mem[16'h0100 + i] = 16'(ex[i]);
	stat(table_min_opcode, 10, 16'h0100, 1'b0);
	chk16(mem[DEST + 16'h0001], 16'h0002);
	stat(table_max_opcode, 10, 16'h0100, 1'b1);
	// Tied extremes: minimum copy placed after its first occurrence, maximum copy placed ahead of it
	mem[16'h0109] = 16'hFC18;
	mem[16'h0103] = 16'h4E20;
	stat(table_max_opcode, 10, 16'h0100, 1'b0);
	chk16(mem[DEST + 16'h0001], 16'h0003);
	stat(table_min_opcode, 10, 16'h0100, 1'b0);
	chk16(mem[DEST + 16'h0001], 16'h0002);
	stat(table_mean_opcode, 10, 16'h0100, 1'b0);
	for (int i = 0; i < 64; i++) mem[16'h0400 + i] = 16'($random(seed));
	mem[16'h040A] = 16'h8000;
	mem[16'h0428] = 16'h7FFF;
	mem[16'h043F] = 16'h8000;
	stat(table_max_opcode, 64, 16'h0400, 1'b0);
	stat(table_min_opcode, 64, 16'h0400, 1'b0);
	stat(table_mean_opcode, 64, 16'h0400, 1'b0);
	stat(table_max_opcode, 1, 16'h0400, 1'b0);
	mem[16'h0500] = 16'hFFFD;
	mem[16'h0501] = 16'hFFFC;
	stat(table_mean_opcode, 2, 16'h0500, 1'b0);
	chk16(mem[DEST], 16'hFFFD);
	// Flag holds while the input stays high, drops when it goes low
	repeat (2) @(negedge sys_clk_in);
	chk1(flag_out, 1'b1);
	instr_in = 1'b0;
	@(negedge sys_clk_in);
	chk1(flag_out, 1'b0);
	quiet(table_mean_opcode, 5, 1'b0, 1'b0);
	quiet(table_max_opcode, 0, 1'b1, 1'b1);
	quiet(table_min_opcode, 65, 1'b1, 1'b1);
	quiet(table_mean_opcode, 127, 1'b1, 1'b1);
	quiet(piecewise_function_opcode, 33, 1'b1, 1'b1);
	quiet(piecewise_function_opcode, 0, 1'b1, 1'b1);
	// Random tables; a narrow value range forces ties
	for (int r = 0; r < 40; r++) begin
		n = 1 + ($unsigned($random(seed)) % 64);
		a = $random(seed);
		for (int i = 0; i < n; i++) mem[16'h0600 + i] = a[0] ? 16'($random(seed) % 3) : 16'($random(seed));
		stat(tsu_op_type'(r % 3), n, 16'h0600, a[1]);
	end
	for (int i = 0; i < 8; i++) mem[FGB + i] = 16'(fx[i]);
	fg(4, 16'd1500);
	chk16(mem[DEST], 16'h057D);
	for (int i = 0; i < 8; i++) fg(4, 16'(xs[i]));
	fg(4, 16'h8000);
	fg(1, 16'h0000);
	for (int r = 0; r < 20; r++) begin
		n = 1 + ($unsigned($random(seed)) % 32);
		a = -20000 + ($unsigned($random(seed)) % 1000);
		for (int i = 0; i < n; i++) begin
			mem[FGB + i] = 16'(a);
			mem[FGB + n + i] = 16'($random(seed));
			a += 1 + ($unsigned($random(seed)) % 1500);
		end
		fg(n, 16'($random(seed) % 30000));
	end
	test_done();
end

endmodule : tsu_table_statistics_unit_tb
